// File: src/tss_consts.vh
// constants for the time-slot switch core: address regions, register
// selects, field positions, reset values and serial timing counts.
// assumes a single clk_sys domain; included by bare name.
`ifndef TSS_CONSTS_VH
`define TSS_CONSTS_VH

`define TSS_REGION_DM   2'h3
`define TSS_REGION_CM   2'h2
`define TSS_REGION_REG  2'h1
`define TSS_SEL_CFG     4'h0
`define TSS_SEL_EDGE    4'h1
`define TSS_SEL_SKEW0   4'h2
`define TSS_SEL_SKEW7   4'h9

`define TSS_CFG_ARM     9
`define TSS_CFG_FILL_HI 8
`define TSS_CFG_FILL_LO 5
`define TSS_CFG_GO      4
`define TSS_CFG_STBY    3
`define TSS_CFG_EVAL    2
`define TSS_CFG_RATE_HI 1
`define TSS_CFG_RATE_LO 0
`define TSS_CFG_RST     16'h0000
`define TSS_CFG_MASK    16'h03FF
`define TSS_REG_RST     16'h0000

`define TSS_CW_SRCSEL   15
`define TSS_CW_DELAY    14
`define TSS_CW_OE       13
`define TSS_CW_LOOP     12
`define TSS_CW_STR_HI   11
`define TSS_CW_STR_LO   7
`define TSS_CW_SLOT_HI  6
`define TSS_CW_SLOT_LO  0

`define TSS_LAST_SLOT_32  7'h1F
`define TSS_LAST_SLOT_64  7'h3F
`define TSS_LAST_SLOT_128 7'h7F
`define TSS_NUM_BANKS     2'h3
`define TSS_BIT_LG        3
`define TSS_FILL_LAST     12'hFFF

`endif

// File: src/tss_dpram.v
// one write port, two registered read ports; used for data and
// connection memory. assumes one clock, no reset on the array.
`default_nettype none

module tss_dpram #(
    parameter AW    = 12,
    parameter DW    = 16,
    parameter DEPTH = 4096
) (
    input  wire          clk_sys,
    input  wire          rst_n,
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [DW-1:0] wr_data,
    input  wire [AW-1:0] ra_addr,
    output reg  [DW-1:0] ra_data,
    input  wire [AW-1:0] rb_addr,
    output reg  [DW-1:0] rb_data
);
    reg [DW-1:0] mem [0:DEPTH-1];

    // array write; contents are undefined until written
    always @(posedge clk_sys) begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
    end

    // read data leave through registers, old data on same-cycle write
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            ra_data <= {DW{1'b0}};
            rb_data <= {DW{1'b0}};
        end else begin
            ra_data <= mem[ra_addr];
            rb_data <= mem[rb_addr];
        end
    end
endmodule // tss_dpram

`default_nettype wire

// File: src/tss_switch_core.v
// time-slot interchange core: serial streams in and out, data and
// connection memories, host RAM-like port and configuration registers.
// assumes pins are asynchronous to clk_sys; one bit cell lasts
// 2**BIT_LG clk_sys cycles (enable from the slot divider).
`default_nettype none
`include "tss_consts.vh"

module tss_switch_core #(
    parameter NS     = 32,
    parameter BIT_LG = `TSS_BIT_LG
) (
    input  wire          clk_sys,
    input  wire          rst_n,
    input  wire          frame_pulse_in_n,
    input  wire          output_drive_pin,
    input  wire [NS-1:0] rx_in,
    output wire [NS-1:0] tx_out,
    output wire [NS-1:0] tx_oe,
    input  wire          host_sel,
    input  wire          host_wr,
    input  wire [13:0]   host_addr,
    input  wire [15:0]   host_wdata,
    output reg  [15:0]   host_rdata,
    output reg           host_ack
);
    localparam CW      = BIT_LG + 3;
    localparam [CW-1:0] CYC_LAST = {CW{1'b1}};
    localparam [CW-1:0] NS_CYC   = NS;
    localparam [BIT_LG-1:0] SUB_LAST = {BIT_LG{1'b1}};
    localparam [BIT_LG-1:0] SUB_MID  = {1'b1, {(BIT_LG-1){1'b0}}};
    localparam SW = NS + 2;
    // frame pulse stages start at its idle high level: no false edge
    localparam [SW-1:0] SY_RST = {1'b0, 1'b1, {NS{1'b0}}};

    // bank step modulo three
    function [1:0] bank_add;
        input [1:0] b;
        input [1:0] k;
        reg   [2:0] s;
        begin
            s = {1'b0, b} + {1'b0, k};
            bank_add = (s >= {1'b0, `TSS_NUM_BANKS}) ?
                       s[1:0] - `TSS_NUM_BANKS : s[1:0];
        end
    endfunction

    // register select decode shared by read and write paths
    function is_skew;
        input [3:0] sel;
        is_skew = (sel >= `TSS_SEL_SKEW0) && (sel <= `TSS_SEL_SKEW7);
    endfunction

    // ---------------- pin synchronisers ----------------
    reg [SW-1:0] sy1_q, sy2_q, sy3_q, syv_q;
    // a change counts only when stages two and three agree
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            sy1_q <= SY_RST;
            sy2_q <= SY_RST;
            sy3_q <= SY_RST;
            syv_q <= SY_RST;
        end else begin
            sy1_q <= {output_drive_pin, frame_pulse_in_n, rx_in};
            sy2_q <= sy1_q;
            sy3_q <= sy2_q;
            syv_q <= (sy2_q & sy3_q) | (syv_q & (sy2_q | sy3_q));
        end
    end
    wire [NS-1:0] rx_v    = syv_q[NS-1:0];
    wire          fp_v    = syv_q[NS];
    wire          drive_v = syv_q[NS+1];

    // ---------------- registers ----------------
    reg  [15:0] cfg_q;
    reg  [15:0] edge_q;
    reg  [15:0] skew_q [0:7];
    reg  [11:0] fill_q;
    wire [1:0]  region = host_addr[13:12];
    wire [3:0]  rsel   = host_addr[11:8];
    wire [2:0]  sk_idx = rsel[2:0] - 3'h2;
    wire        h_wr   = host_sel & host_wr;
    wire        hw_reg = h_wr && (region == `TSS_REGION_REG);
    wire        hw_cm  = h_wr && (region == `TSS_REGION_CM);
    wire        standby = cfg_q[`TSS_CFG_STBY];
    wire [1:0]  rate   = cfg_q[`TSS_CFG_RATE_HI:`TSS_CFG_RATE_LO];
    wire        fill_busy = cfg_q[`TSS_CFG_GO] & cfg_q[`TSS_CFG_ARM];
    wire        fill_done = fill_busy & ~hw_cm & (fill_q == `TSS_FILL_LAST);
    integer     i;

    // host write wins over the hardware clear of the go bit
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            cfg_q  <= `TSS_CFG_RST;
            edge_q <= `TSS_REG_RST;
            for (i = 0; i < 8; i = i + 1)
                skew_q[i] <= `TSS_REG_RST;
        end else begin
            if (fill_done | ~cfg_q[`TSS_CFG_ARM])
                cfg_q[`TSS_CFG_GO] <= 1'b0;
            if (hw_reg && rsel == `TSS_SEL_CFG)
                cfg_q <= host_wdata & `TSS_CFG_MASK;
            if (hw_reg && rsel == `TSS_SEL_EDGE)
                edge_q <= host_wdata;
            if (hw_reg && is_skew(rsel))
                skew_q[sk_idx] <= host_wdata;
        end
    end

    // fill address walks the whole connection memory, pausing for host
    always @(posedge clk_sys) begin
        if (!rst_n || !fill_busy)
            fill_q <= 12'h000;
        else if (!hw_cm)
            fill_q <= fill_q + 12'h001;
    end

    // ---------------- slot and frame timing ----------------
    reg  [CW-1:0] cyc_q;
    reg  [6:0]    slot_q;
    reg  [1:0]    bank_q;
    reg           fp_prev_q;
    // rate field sets the frame length for both directions
    wire [6:0] last_slot = (rate == 2'h0) ? `TSS_LAST_SLOT_32 :
                           (rate == 2'h1) ? `TSS_LAST_SLOT_64 :
                                            `TSS_LAST_SLOT_128;
    wire [6:0] nxt_slot  = (slot_q == last_slot) ? 7'h00 : slot_q + 7'h01;
    wire       fp_fall   = fp_prev_q & ~fp_v;
    wire       at_start  = (cyc_q == {CW{1'b0}}) && (slot_q == 7'h00);
    wire       slot_end  = (cyc_q == CYC_LAST);
    wire       fp_go     = fp_fall & ~at_start;
    wire       new_frame = (slot_end & (slot_q == last_slot)) | fp_go;
    wire       slot_load = slot_end | fp_go;
    wire [BIT_LG-1:0] sub = cyc_q[BIT_LG-1:0];

    // the frame pulse re-aligns slot zero and advances the write bank
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            cyc_q     <= {CW{1'b0}};
            slot_q    <= 7'h00;
            bank_q    <= 2'h0;
            fp_prev_q <= 1'b1;
        end else begin
            fp_prev_q <= fp_v;
            cyc_q     <= fp_go ? {CW{1'b0}} : cyc_q + {{(CW-1){1'b0}}, 1'b1};
            if (new_frame) begin
                slot_q <= 7'h00;
                bank_q <= bank_add(bank_q, 2'h1);
            end else if (slot_end)
                slot_q <= nxt_slot;
        end
    end

    // ---------------- memories ----------------
    wire        dm_we;
    wire [13:0] dm_wa, dm_ra;
    wire [7:0]  dm_wd, dm_rda, dm_rdb;
    wire        cm_we = hw_cm | fill_busy;
    wire [11:0] cm_wa = hw_cm ? host_addr[11:0] : fill_q;
    wire [15:0] cm_wd = hw_cm ? host_wdata :
        {cfg_q[`TSS_CFG_FILL_HI:`TSS_CFG_FILL_LO], 12'h000};
    wire [11:0] cm_ra = {cyc_q[4:0], nxt_slot};
    wire [15:0] cm_rda, cm_rdb;
    reg  [1:0]  wr_bank_q;

    // data memory only fills from the inputs; host writes are dropped
    tss_dpram #(.AW(14), .DW(8), .DEPTH(3 * 4096)) u_dm (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .wr_en   (dm_we),
        .wr_addr (dm_wa),
        .wr_data (dm_wd),
        .ra_addr (dm_ra),
        .ra_data (dm_rda),
        .rb_addr ({wr_bank_q, host_addr[11:0]}),
        .rb_data (dm_rdb)
    );

    tss_dpram #(.AW(12), .DW(16), .DEPTH(4096)) u_cm (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .wr_en   (cm_we),
        .wr_addr (cm_wa),
        .wr_data (cm_wd),
        .ra_addr (cm_ra),
        .ra_data (cm_rda),
        .rb_addr (host_addr[11:0]),
        .rb_data (cm_rdb)
    );

    // ---------------- prefetch of next slot ----------------
    reg        p1_v_q, p2_v_q;
    reg [4:0]  p1_s_q, p2_s_q;
    reg [15:0] p2_w_q;
    reg [7:0]  nxt_byte_q [0:NS-1];
    reg [3:0]  nxt_ctl_q  [0:NS-1];
    // bank of the frame that the next slot belongs to
    wire [1:0] fb = (nxt_slot == 7'h00) ? bank_add(bank_q, 2'h1) : bank_q;
    wire [6:0] src_slot = cm_rda[`TSS_CW_SLOT_HI:`TSS_CW_SLOT_LO];
    // same frame only when already written: m > n + 2
    wire       far_dst  = {1'b0, nxt_slot} > ({1'b0, src_slot} + 8'h02);
    wire [1:0] rd_bank  =
        cm_rda[`TSS_CW_DELAY] ? bank_add(fb, 2'h1) :
        far_dst ? fb : bank_add(fb, 2'h2);
    assign dm_ra = {rd_bank, cm_rda[`TSS_CW_STR_HI:`TSS_CW_STR_LO],
                    src_slot};

    // three-stage pipe: word read, data read, byte stored per stream
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            p1_v_q <= 1'b0;
            p2_v_q <= 1'b0;
            p1_s_q <= 5'h00;
            p2_s_q <= 5'h00;
            p2_w_q <= 16'h0000;
        end else begin
            p1_v_q <= (cyc_q < NS_CYC);
            p1_s_q <= cyc_q[4:0];
            p2_v_q <= p1_v_q;
            p2_s_q <= p1_s_q;
            p2_w_q <= cm_rda;
        end
    end

    // host byte repeats each frame because its connection word is re-read every frame
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            for (i = 0; i < NS; i = i + 1) begin
                nxt_byte_q[i] <= 8'h00;
                nxt_ctl_q[i]  <= 4'h0;
            end
        end else if (p2_v_q) begin
            nxt_byte_q[p2_s_q] <= p2_w_q[`TSS_CW_SRCSEL] ?
                                  p2_w_q[7:0] : dm_rda;
            nxt_ctl_q[p2_s_q]  <= p2_w_q[15:12];
        end
    end

    // ---------------- per-stream serial lanes ----------------
    reg [7:0]  in_hold_q [0:NS-1];
    reg [6:0]  wr_slot_q;
    reg        wr_v_q;
    wire       glob_en = drive_v | standby;

    genvar g;
    generate
        for (g = 0; g < NS; g = g + 1) begin : g_lane
            reg [7:0] out_sh_q, in_sh_q;
            reg [3:0] ctl_q;
            reg       oe_q;
            // loop bit feeds the lane's own transmit bit back in
            wire rx_bit = ctl_q[`TSS_CW_LOOP - 12] ?
                          out_sh_q[7] : rx_v[g];
            always @(posedge clk_sys) begin
                if (!rst_n) begin
                    out_sh_q     <= 8'h00;
                    in_sh_q      <= 8'h00;
                    ctl_q        <= 4'h0;
                    oe_q         <= 1'b0;
                    in_hold_q[g] <= 8'h00;
                end else begin
                    if (slot_load) begin
                        out_sh_q <= nxt_byte_q[g];
                        ctl_q    <= nxt_ctl_q[g];
                    end else if (sub == SUB_LAST)
                        out_sh_q <= {out_sh_q[6:0], 1'b0};
                    if (sub == SUB_MID)
                        in_sh_q <= {in_sh_q[6:0], rx_bit};
                    if (slot_end)
                        in_hold_q[g] <= in_sh_q;
                    // channel enable gates the global enables
                    oe_q <= ctl_q[`TSS_CW_OE - 12] & glob_en;
                end
            end
            assign tx_out[g] = out_sh_q[7];
            assign tx_oe[g]  = oe_q;
        end
    endgenerate

    // finished bytes are written during the next slot, one per cycle
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            wr_slot_q <= 7'h00;
            wr_bank_q <= 2'h0;
            wr_v_q    <= 1'b0;
        end else if (slot_end) begin
            wr_slot_q <= slot_q;
            wr_bank_q <= bank_q;
            wr_v_q    <= 1'b1;
        end
    end
    assign dm_we = wr_v_q & (cyc_q < NS_CYC);
    assign dm_wa = {wr_bank_q, cyc_q[4:0], wr_slot_q};
    assign dm_wd = in_hold_q[cyc_q[4:0]];

    // ---------------- host read answer ----------------
    reg [1:0]  rreg_region_q;
    reg [15:0] rreg_val_q;
    reg        rd_pend_q;
    reg [15:0] reg_val;
    reg [15:0] rdata_q;
    // register snapshot; go reads back as the fill-busy status
    always @* begin
        reg_val = 16'h0000;
        if (rsel == `TSS_SEL_CFG)
            reg_val = cfg_q;
        else if (rsel == `TSS_SEL_EDGE)
            reg_val = edge_q;
        else if (is_skew(rsel))
            reg_val = skew_q[sk_idx];
    end

    // read data stand with the ack, all from flops; then held in rdata_q
    always @* begin
        case ({rd_pend_q, rreg_region_q})
            {1'b1, `TSS_REGION_DM}:  host_rdata = {8'h00, dm_rdb};
            {1'b1, `TSS_REGION_CM}:  host_rdata = cm_rdb;
            {1'b1, `TSS_REGION_REG}: host_rdata = rreg_val_q;
            {1'b1, 2'h0}:            host_rdata = 16'h0000;
            default:                 host_rdata = rdata_q;
        endcase
    end

    // every access is answered one cycle after it is taken
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            rreg_region_q <= 2'h0;
            rreg_val_q    <= 16'h0000;
            rd_pend_q     <= 1'b0;
            rdata_q       <= 16'h0000;
            host_ack      <= 1'b0;
        end else begin
            rd_pend_q     <= host_sel & ~host_wr;
            rreg_region_q <= region;
            rreg_val_q    <= reg_val;
            rdata_q       <= host_rdata;
            host_ack      <= host_sel;
        end
    end
endmodule // tss_switch_core

`default_nettype wire

// File: tb/tss_core_sva.sv
// checker on the core ports: host access timing and serial pacing.
// assumes BIT_LG=3 (8 clk cells) and one clk_sys domain.
`default_nettype none
module tss_core_sva #(
    parameter NS = 32
) (
    input wire logic          clk_sys,
    input wire logic          rst_n,
    input wire logic          host_sel,
    input wire logic          host_wr,
    input wire logic [13:0]   host_addr,
    input wire logic [15:0]   host_rdata,
    input wire logic          host_ack,
    input wire logic [NS-1:0] tx_out,
    input wire logic [NS-1:0] tx_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_ack_next;
        host_sel |=> host_ack;
    endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("access not answered next cycle");
    property p_ack_idle;
        !host_sel |=> !host_ack;
    endproperty
    a_ack_idle: assert property (p_ack_idle)
        else $error("answer without access");
    property p_rd_hold;
        !(host_sel && !host_wr) |=> $stable(host_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data moved without a read");
    property p_blank_rd;
        host_sel && !host_wr && host_addr[13:12] == 2'h0
            |=> host_rdata == 16'h0000;
    endproperty
    a_blank_rd: assert property (p_blank_rd)
        else $error("unmapped region read not zero");
    property p_cfg_rd;
        host_sel && !host_wr && host_addr[13:8] == 6'h10
            |=> host_rdata[15:10] == 6'h00;
    endproperty
    a_cfg_rd: assert property (p_cfg_rd)
        else $error("config unused bits not zero");
    property p_dm_rd;
        host_sel && !host_wr && host_addr[13:12] == 2'h3
            |=> host_rdata[15:8] == 8'h00;
    endproperty
    a_dm_rd: assert property (p_dm_rd)
        else $error("data memory read upper byte not zero");
    // a stream bit lasts one whole cell of 8 clk
    property p_cell;
        $changed(tx_out) |=> $stable(tx_out) [*7];
    endproperty
    a_cell: assert property (p_cell)
        else $error("serial bit shorter than a cell");
    // after a change the enables hold for 8 more clk; alignment to slot starts is not checked
    property p_slot_oe;
        $changed(tx_oe) |=> $stable(tx_oe) [*8];
    endproperty
    a_slot_oe: assert property (p_slot_oe)
        else $error("output enable moved inside a slot");
endmodule // tss_core_sva
bind tss_switch_core tss_core_sva #(.NS(NS)) sva_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .host_sel(host_sel),
    .host_wr(host_wr), .host_addr(host_addr), .host_rdata(host_rdata),
    .host_ack(host_ack), .tx_out(tx_out), .tx_oe(tx_oe));
`default_nettype wire

// File: tb/tss_stream_src.sv
// far-side streams: frame pulse and 32 slots of 64 clk per frame.
// stream s, slot k sends {frame count, s[0], k}, MSB first.
`default_nettype none
module tss_stream_src #(
    parameter NS = 32
) (
    input  wire logic     clk_sys,
    input  wire logic     rst_n,
    output logic          frame_pulse_in_n,
    output logic [NS-1:0] rx_in,
    output logic [1:0]    frame_q
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [10:0] cyc_q = 11'h000;
    logic [1:0]  cnt_q = 2'h0;
    logic [7:0]  byte_v;
    // frame timing free-runs; the count lets the bench see frame delay
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            cyc_q <= 11'h000;
            cnt_q <= 2'h0;
        end else begin
            cyc_q <= cyc_q + 11'h001;
            if (cyc_q == 11'h7FF) begin
                cnt_q <= cnt_q + 2'h1;
            end
        end
    end
    assign frame_q = cnt_q;
    // pulse low for the first cell of a frame, idle high
    assign frame_pulse_in_n = !rst_n || (cyc_q[10:3] != 8'h00);
    // one bit per 8 clk cell, slot byte MSB first
    always_comb begin
        for (int s = 0; s < NS; s++) begin
            byte_v = {cnt_q, s[0], cyc_q[10:6]};
            rx_in[s] = byte_v[~cyc_q[5:3]];
        end
    end
endmodule // tss_stream_src
`default_nettype wire

// File: tb/tdm_time_slot_switch_core_test.sv
// self-checking bench for the switch core with host tasks.
// assumes the stream model and checker files are compiled first.
`default_nettype none
module tdm_time_slot_switch_core_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        drive_pin = 1'b0;
    logic        host_sel = 1'b0;
    logic        host_wr = 1'b0;
    logic [13:0] host_addr = 14'h0000;
    logic [15:0] host_wdata = 16'h0000;
    logic [15:0] host_rdata, rd;
    logic        host_ack, fp_n;
    logic [31:0] rx, tx, oe;
    logic [1:0]  frm;
    int          fail_count = 0;
    int          cmp_count = 0;
    int          tick = 0;
    tss_switch_core #(.NS(32), .BIT_LG(3)) dut_u (
        .clk_sys(clk_sys), .rst_n(rst_n), .frame_pulse_in_n(fp_n),
        .output_drive_pin(drive_pin), .rx_in(rx), .tx_out(tx),
        .tx_oe(oe), .host_sel(host_sel), .host_wr(host_wr),
        .host_addr(host_addr), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .host_ack(host_ack));
    tss_stream_src #(.NS(32)) src_u (.clk_sys(clk_sys), .rst_n(rst_n),
        .frame_pulse_in_n(fp_n), .rx_in(rx), .frame_q(frm));
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    // hang guard: the whole run needs about 25k cycles
    always @(posedge clk_sys) begin
        tick <= tick + 1;
        if (tick == 60000) begin
            fail_count++;
            finish_test();
        end
    end
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one-cycle access; answer taken the cycle after it
    task automatic acc(input logic w, input logic [13:0] a,
                       input logic [15:0] d);
        @(posedge clk_sys) #1;
        host_sel = 1'b1;
        host_wr = w;
        host_addr = a;
        host_wdata = d;
        @(posedge clk_sys) #1;
        host_sel = 1'b0;
        rd = host_rdata;
        check("ack", {15'h0, host_ack}, 16'h0001);
    endtask
    task automatic rd_chk(input string what, input logic [13:0] a,
                          input logic [15:0] exp);
        acc(1'b0, a, 16'h0000);
        check(what, rd, exp);
    endtask
    // catch the next enabled slot of stream 0, sample mid cell
    task automatic grab(output logic [7:0] b, output logic ok);
        int n = 0;
        while (oe[0] === 1'b1 && n < 100) begin
            @(posedge clk_sys) #1;
            n++;
        end
        while (oe[0] !== 1'b1 && n < 3000) begin
            @(posedge clk_sys) #1;
            n++;
        end
        ok = (n < 3000);
        repeat (3) @(posedge clk_sys);
        for (int k = 7; k >= 0; k--) begin
            @(posedge clk_sys) #1;
            b[k] = tx[0];
            repeat (7) @(posedge clk_sys);
        end
        #1;
    endtask
    task automatic t_regs;
        acc(1'b1, 14'h1000, 16'hFC04);
        rd_chk("config", 14'h10FF, 16'h0004);
        for (int i = 1; i < 10; i++) begin
            acc(1'b1, {2'h1, i[3:0], 8'h5A}, {12'h3C0, i[3:0]});
            rd_chk("reg", {2'h1, i[3:0], 8'h00}, {12'h3C0, i[3:0]});
            acc(1'b1, {2'h1, i[3:0], 8'h00}, 16'h0000);
        end
        rd_chk("blank", 14'h0123, 16'h0000);
    endtask
    task automatic t_fill(input logic [15:0] cfg, input logic [15:0] w);
        int n = 0;
        acc(1'b1, 14'h1000, cfg);
        do begin
            repeat (200) @(posedge clk_sys);
            acc(1'b0, 14'h1000, 16'h0000);
            n++;
        end while (rd[4] !== 1'b0 && n < 40);
        check("go clear", rd, cfg & 16'h03EF);
        rd_chk("cm low", 14'h2000, w);
        rd_chk("cm high", 14'h2FFF, w);
    endtask
    task automatic t_proc;
        logic [7:0] b;
        logic       ok;
        acc(1'b1, 14'h2005, 16'hA3C5);
        acc(1'b1, 14'h1000, 16'h0008);
        grab(b, ok);
        check("host byte", {8'h00, b}, 16'h00C5);
        check("slot end", {15'h0, oe[0]}, 16'h0000);
        grab(b, ok);
        check("repeat", {8'h00, b}, 16'h00C5);
        drive_pin = 1'b1;
        // let the pin pass its synchroniser before standby drops
        repeat (8) @(posedge clk_sys);
        acc(1'b1, 14'h1000, 16'h0000);
        grab(b, ok);
        check("pin on", {15'h0, ok}, 16'h0001);
        drive_pin = 1'b0;
        grab(b, ok);
        check("all off", {15'h0, ok}, 16'h0000);
        acc(1'b1, 14'h2005, 16'h0000);
        acc(1'b1, 14'h1000, 16'h0008);
    endtask
    // route slot n of stream src to slot m of stream 0, d frames late
    task automatic path(input logic md, input logic [1:0] src,
        input logic [4:0] n, input logic [4:0] m, input logic [1:0] d);
        logic [7:0] b;
        logic       ok;
        logic [1:0] f;
        acc(1'b1, {7'h40, 2'h0, m}, {1'b0, md, 5'h10, src, 2'h0, n});
        grab(b, ok);
        f = frm;
        check("path", {8'h00, b}, {8'h00, f - d, src[0], n});
        acc(1'b1, {7'h40, 2'h0, m}, 16'h0000);
    endtask
    task automatic t_delay;
        path(1'b0, 2'h3, 5'd10, 5'd20, 2'd0);
        path(1'b0, 2'h2, 5'd10, 5'd12, 2'd1);
        path(1'b0, 2'h1, 5'd10, 5'd5, 2'd1);
        path(1'b1, 2'h3, 5'd10, 5'd20, 2'd2);
        path(1'b1, 2'h2, 5'd31, 5'd0, 2'd2);
    endtask
    task automatic t_loop;
        logic [7:0] b;
        logic       ok;
        acc(1'b1, 14'h2007, 16'hB05C);
        // wait out the looped slot so its byte is in the newest bank
        grab(b, ok);
        check("loop tx", {8'h00, b}, 16'h005C);
        rd_chk("loop", 14'h3007, 16'h005C);
        acc(1'b1, 14'h3007, 16'h1234);
        rd_chk("dm kept", 14'h3007, 16'h005C);
        acc(1'b0, 14'h3084, 16'h0000);
        check("dm src", rd & 16'hFF3F, 16'h0024);
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        t_regs();
        t_fill(16'h0350, 16'hA000);
        t_fill(16'h0210, 16'h0000);
        t_proc();
        t_delay();
        t_loop();
        finish_test();
    end
endmodule // tdm_time_slot_switch_core_test
`default_nettype wire
